// ==== core/arpf_core.v ====
// Purpose: Formats received async packets into quadlet sequences with a trailer
// Assumes: Receiver presents one packet at a time, ack and speed valid with last
// Notes:   Quadlet packets are held whole so the FIFO trailer can lead
`default_nettype none
`include "arpf_consts.vh"

// Operation
// - Trailer counts header and payload quadlets only
// - Trailer carries 5-bit acknowledge code
// - Speed coded 00/01/10, never 11
// - Target address split into bus and node
// - Transaction label passed through unchanged
// - Retry code delivered with its four encodings
// - Sender address in upper half of quadlet two
// - Target offset 48 bits, quadlet aligned
// - Lock response: top offset bits are response code
// - Quadlet data only for writes and read responses
// - Block first quadlet: target then control bits
// - Block data only for writes, read responses and lock requests and responses
// - FIFO block packets end with the trailer
// - FIFO quadlet packets start with the trailer
// - Last data quadlet zero padded, byte 0 first
// - Length counts data bytes only
module arpf_core (
  // Clock and reset
  input  wire        i_clock,
  input  wire        i_resetn,
  input  wire        i_clock_en,
  // Mode: high selects data mover port format
  input  wire        i_data_mover_port,
  // Receiver stream
  input  wire        i_rx_valid,
  input  wire [31:0] i_rx_data,
  input  wire        i_rx_last,
  input  wire [4:0]  i_rx_acknowledge_code,
  input  wire [1:0]  i_rx_speed,
  output wire        o_rx_ready,
  // Formatted stream
  output reg         o_out_valid,
  output reg  [31:0] o_out_data,
  output reg         o_out_last,
  input  wire        i_out_ready,
  // Decoded header
  output reg         o_header_valid,
  output reg  [9:0]  o_bus_number,
  output reg  [5:0]  o_node_number,
  output reg  [5:0]  o_transaction_label,
  output reg  [1:0]  o_retry_code,
  output reg  [3:0]  o_transaction_code,
  output reg  [3:0]  o_priority,
  output reg  [15:0] o_sender_node_address,
  output reg  [47:0] o_target_offset,
  output reg  [3:0]  o_response_code,
  output reg         o_offset_misaligned,
  output reg  [15:0] o_payload_byte_length,
  output reg  [15:0] o_extended_transaction_code
);
  reg  [2:0]  state;
  reg  [2:0]  wr_idx;
  reg  [1:0]  rd_idx;
  reg  [2:0]  emit_cnt;
  reg  [14:0] data_left;
  reg  [13:0] quad_count;
  reg  [4:0]  ack_code;
  reg  [1:0]  speed;
  reg         dm_mode;
  reg         rx_done;
  reg  [1:0]  pad_sel;
  wire [31:0] store_rd;
  wire        out_free = !o_out_valid || i_out_ready;
  wire        rx_take = i_rx_valid && o_rx_ready;
  wire [3:0]  cur_transaction_code = (wr_idx == 3'h0) ? i_rx_data[`ARPF_F_TRANSACTION_CODE] : o_transaction_code;
  wire        cur_dm = (wr_idx == 3'h0) ? i_data_mover_port : dm_mode;
  wire        is_block = (cur_transaction_code == `ARPF_TC_WR_BLOCK) || (cur_transaction_code == `ARPF_TC_RD_BLOCK) ||
                         (cur_transaction_code == `ARPF_TC_RD_BRESP) || (cur_transaction_code == `ARPF_TC_LOCK_REQ) ||
                         (cur_transaction_code == `ARPF_TC_LOCK_RESP);
  // Only writes, read responses and locks carry a payload
  wire        block_data = is_block && (cur_transaction_code != `ARPF_TC_RD_BLOCK);
  wire        quad_data = (cur_transaction_code == `ARPF_TC_WR_QUAD) ||
                          (cur_transaction_code == `ARPF_TC_RD_QRESP);
  wire        trailer_first = !dm_mode && !is_block;
  wire [16:0] len_round = {1'b0, i_rx_data[`ARPF_F_LENGTH]} + 17'h0_0003;
  wire [2:0]  stored_n = (wr_idx == `ARPF_STORE_DEPTH) ? wr_idx : wr_idx + 3'h1;
  wire [2:0]  quad_cap = quad_data ? `ARPF_QUAD_WITH_DAT : `ARPF_QUAD_HDR;
  wire [2:0]  keep_n = (!is_block && (stored_n > quad_cap)) ? quad_cap : stored_n;
  wire [31:0] trailer = {2'h0, quad_count, 3'h0, ack_code, 2'h0, speed, 4'h0};
  reg  [31:0] pad_mask;

  // Bytes past the length become zero; byte 0 is the most significant lane
  always @* begin
    pad_mask = 32'hFFFF_FFFF;
    if (data_left == 15'h0001) begin
      case (pad_sel)
        2'h1:    pad_mask = 32'hFF00_0000;
        2'h2:    pad_mask = 32'hFFFF_0000;
        2'h3:    pad_mask = 32'hFFFF_FF00;
        default: pad_mask = 32'hFFFF_FFFF;
      endcase
    end
  end

  // Input stalls while stored quadlets or the trailer are going out
  assign o_rx_ready = (state == `ARPF_S_COLLECT) ||
                      ((state == `ARPF_S_DATA) && (out_free || (data_left == 15'h0000)));

  arpf_store u_store (
    .i_clock    (i_clock),
    .i_resetn   (i_resetn),
    .i_clock_en (i_clock_en),
    .i_wr_en    (rx_take && (state == `ARPF_S_COLLECT) && (wr_idx != `ARPF_STORE_DEPTH)),
    .i_wr_index (wr_idx[1:0]),
    .i_wr_data  (i_rx_data),
    .i_rd_index (rd_idx),
    .o_rd_data  (store_rd)
  );

  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state                       <= `ARPF_S_COLLECT;
      wr_idx                      <= 3'h0;
      rd_idx                      <= 2'h0;
      emit_cnt                    <= 3'h0;
      data_left                   <= 15'h0000;
      quad_count                  <= 14'h0000;
      ack_code                    <= 5'h00;
      speed                       <= 2'h0;
      dm_mode                     <= 1'b0;
      rx_done                     <= 1'b0;
      pad_sel                     <= 2'h0;
      o_out_valid                 <= 1'b0;
      o_out_data                  <= 32'h0000_0000;
      o_out_last                  <= 1'b0;
      o_header_valid              <= 1'b0;
      o_bus_number                <= 10'h000;
      o_node_number               <= 6'h00;
      o_transaction_label         <= 6'h00;
      o_retry_code                <= 2'h0;
      o_transaction_code          <= 4'h0;
      o_priority                  <= 4'h0;
      o_sender_node_address       <= 16'h0000;
      o_target_offset             <= 48'h0000_0000_0000;
      o_response_code             <= 4'h0;
      o_offset_misaligned         <= 1'b0;
      o_payload_byte_length       <= 16'h0000;
      o_extended_transaction_code <= 16'h0000;
    end else if (i_clock_en) begin
      o_header_valid <= 1'b0;
      if (i_out_ready) begin
        o_out_valid <= 1'b0;
      end
      case (state)
        `ARPF_S_COLLECT: begin
          if (rx_take) begin
            if (wr_idx != `ARPF_STORE_DEPTH) begin
              wr_idx <= wr_idx + 3'h1;
            end
            case (wr_idx)
              3'h0: begin
                dm_mode             <= i_data_mover_port;
                o_bus_number        <= i_rx_data[`ARPF_F_BUS];
                o_node_number       <= i_rx_data[`ARPF_F_NODE];
                o_transaction_label <= i_rx_data[`ARPF_F_LABEL];
                o_retry_code        <= i_rx_data[`ARPF_F_RETRY];
                o_transaction_code  <= i_rx_data[`ARPF_F_TRANSACTION_CODE];
                // Delivered as received; cable senders are expected to send zero
                o_priority          <= i_rx_data[`ARPF_F_PRIORITY];
              end
              3'h1: begin
                o_sender_node_address   <= i_rx_data[`ARPF_F_SENDER];
                o_target_offset[47:32]  <= i_rx_data[`ARPF_F_OFS_UPPER];
                o_response_code         <= (cur_transaction_code == `ARPF_TC_LOCK_RESP) ?
                                           i_rx_data[`ARPF_F_RCODE] : 4'h0;
              end
              3'h2: begin
                o_target_offset[31:0] <= i_rx_data;
                o_offset_misaligned   <= (i_rx_data[1:0] != 2'h0);
              end
              3'h3: begin
                if (is_block) begin
                  o_payload_byte_length       <= i_rx_data[`ARPF_F_LENGTH];
                  o_extended_transaction_code <= i_rx_data[`ARPF_F_EXT_TRANSACTION_CODE];
                  pad_sel                     <= i_rx_data[17:16];
                  data_left <= block_data ? len_round[16:2] : 15'h0000;
                end
              end
              default: begin
              end
            endcase
            if (i_rx_last) begin
              ack_code       <= i_rx_acknowledge_code;
              speed          <= (i_rx_speed == `ARPF_SPD_BAD) ? `ARPF_SPD_400 : i_rx_speed;
              rx_done        <= 1'b1;
              emit_cnt       <= keep_n;
              quad_count     <= {11'h000, keep_n};
              rd_idx         <= 2'h0;
              o_header_valid <= 1'b1;
              state <= (!cur_dm && !is_block) ? `ARPF_S_TRAIL_FIRST : `ARPF_S_STORED;
            end else if ((wr_idx == 3'h3) && is_block) begin
              rx_done        <= 1'b0;
              emit_cnt       <= `ARPF_BLOCK_HDR;
              quad_count     <= {11'h000, `ARPF_BLOCK_HDR};
              rd_idx         <= 2'h0;
              o_header_valid <= 1'b1;
              state          <= `ARPF_S_STORED;
            end
          end
        end
        `ARPF_S_TRAIL_FIRST: begin
          if (out_free) begin
            o_out_valid <= 1'b1;
            o_out_data  <= trailer;
            o_out_last  <= 1'b0;
            state       <= `ARPF_S_STORED;
          end
        end
        `ARPF_S_STORED: begin
          if (out_free) begin
            o_out_valid <= 1'b1;
            o_out_data  <= store_rd;
            o_out_last  <= trailer_first && ({1'b0, rd_idx} == emit_cnt - 3'h1);
            rd_idx      <= rd_idx + 2'h1;
            if ({1'b0, rd_idx} == emit_cnt - 3'h1) begin
              if (!rx_done) begin
                state <= `ARPF_S_DATA;
              end else if (trailer_first) begin
                state  <= `ARPF_S_COLLECT;
                wr_idx <= 3'h0;
              end else begin
                state <= `ARPF_S_TRAIL_LAST;
              end
            end
          end
        end
        `ARPF_S_DATA: begin
          if (rx_take) begin
            // Quadlets beyond the length are dropped, not forwarded
            if (data_left != 15'h0000) begin
              o_out_valid <= 1'b1;
              o_out_data  <= i_rx_data & pad_mask;
              o_out_last  <= 1'b0;
              data_left   <= data_left - 15'h0001;
              quad_count  <= quad_count + 14'h0001;
            end
            if (i_rx_last) begin
              ack_code <= i_rx_acknowledge_code;
              speed    <= (i_rx_speed == `ARPF_SPD_BAD) ? `ARPF_SPD_400 : i_rx_speed;
              state    <= `ARPF_S_TRAIL_LAST;
            end
          end
        end
        `ARPF_S_TRAIL_LAST: begin
          if (out_free) begin
            o_out_valid <= 1'b1;
            o_out_data  <= trailer;
            o_out_last  <= 1'b1;
            wr_idx      <= 3'h0;
            state       <= `ARPF_S_COLLECT;
          end
        end
        default: begin
          state  <= `ARPF_S_COLLECT;
          wr_idx <= 3'h0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== inc/arpf_consts.vh ====
// Purpose: Constants for the async receive packet formatter
// Assumes: Quadlets are 32 bits, bit 31 is the first bit on the bus
// Notes:   Field positions are given as bit ranges of one quadlet
`ifndef ARPF_CONSTS_VH
`define ARPF_CONSTS_VH

// Formatter states
`define ARPF_S_COLLECT     3'h0
`define ARPF_S_TRAIL_FIRST 3'h1
`define ARPF_S_STORED      3'h2
`define ARPF_S_DATA        3'h3
`define ARPF_S_TRAIL_LAST  3'h4

// Transaction codes
`define ARPF_TC_WR_QUAD    4'h0
`define ARPF_TC_WR_BLOCK   4'h1
`define ARPF_TC_WR_RESP    4'h2
`define ARPF_TC_RD_QUAD    4'h4
`define ARPF_TC_RD_BLOCK   4'h5
`define ARPF_TC_RD_QRESP   4'h6
`define ARPF_TC_RD_BRESP   4'h7
`define ARPF_TC_LOCK_REQ   4'h9
`define ARPF_TC_LOCK_RESP  4'hB

// Header field ranges, first header quadlet
`define ARPF_F_TARGET      31:16
`define ARPF_F_BUS         31:22
`define ARPF_F_NODE        21:16
`define ARPF_F_LABEL       15:10
`define ARPF_F_RETRY       9:8
`define ARPF_F_TRANSACTION_CODE       7:4
`define ARPF_F_PRIORITY    3:0
// Second header quadlet
`define ARPF_F_SENDER      31:16
`define ARPF_F_OFS_UPPER   15:0
`define ARPF_F_RCODE       15:12
// Fourth header quadlet of block packets
`define ARPF_F_LENGTH      31:16
`define ARPF_F_EXT_TRANSACTION_CODE   15:0

// Header sizes in quadlets
`define ARPF_QUAD_HDR      3'h3
`define ARPF_QUAD_WITH_DAT 3'h4
`define ARPF_BLOCK_HDR     3'h4
`define ARPF_STORE_DEPTH   3'h4

// Speed codes
`define ARPF_SPD_400       2'h2
`define ARPF_SPD_BAD       2'h3

`endif

// ==== core/arpf_store.v ====
// Purpose: Four-quadlet holding store for packet headers
// Assumes: One write and one read port, write index below depth
// Notes:   Read is combinational from the addressed entry
`default_nettype none
module arpf_store (
  // Clock and reset
  input  wire        i_clock,
  input  wire        i_resetn,
  input  wire        i_clock_en,
  // Write port
  input  wire        i_wr_en,
  input  wire [1:0]  i_wr_index,
  input  wire [31:0] i_wr_data,
  // Read port
  input  wire [1:0]  i_rd_index,
  output wire [31:0] o_rd_data
);
  wire [31:0] entry [0:3];

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_entry
      reg [31:0] quad;
      always @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
          quad <= 32'h0000_0000;
        end else if (i_clock_en && i_wr_en && (i_wr_index == g)) begin
          quad <= i_wr_data;
        end
      end
      assign entry[g] = quad;
    end
  endgenerate

  assign o_rd_data = entry[i_rd_index];
endmodule
`default_nettype wire

// ==== sim/arpf_core_assertions.sv ====
// Purpose: Concurrent checks on decoded header fields and output hold
// Assumes: First quadlets taken after reset or after a last form the header
// Notes:   Packets shorter than three quadlets are still judged, against shadow entries left by earlier packets
`default_nettype none
module arpf_core_checker (
  // Clock and reset
  input wire logic        i_clock,
  input wire logic        i_resetn,
  input wire logic        i_clock_en,
  // Streams
  input wire logic        i_rx_valid,
  input wire logic [31:0] i_rx_data,
  input wire logic        i_rx_last,
  input wire logic        o_rx_ready,
  input wire logic        o_out_valid,
  input wire logic [31:0] o_out_data,
  input wire logic        i_out_ready,
  // Decoded header
  input wire logic        o_header_valid,
  input wire logic [9:0]  o_bus_number,
  input wire logic [5:0]  o_node_number,
  input wire logic [5:0]  o_transaction_label,
  input wire logic [1:0]  o_retry_code,
  input wire logic [3:0]  o_transaction_code,
  input wire logic [3:0]  o_priority,
  input wire logic [15:0] o_sender_node_address,
  input wire logic [47:0] o_target_offset,
  input wire logic        o_offset_misaligned,
  input wire logic [3:0]  o_response_code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]  idx;
  logic [31:0] hq [0:3];
  logic        take;
  assign take = i_clock_en && i_rx_valid && o_rx_ready;
  // Shadow of the header as taken; data quadlets all land in the last slot
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      idx <= 2'h0;
    end else if (take) begin
      hq[idx] <= i_rx_data;
      idx     <= i_rx_last ? 2'h0 : (idx == 2'h3 ? idx : idx + 2'h1);
    end
  end
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);
  bus_node_a: assert property (
    o_header_valid |-> {o_bus_number, o_node_number} == hq[0][31:16])
    else $error("target address split wrong");
  label_pass_a: assert property (o_header_valid |-> o_transaction_label == hq[0][15:10])
    else $error("label changed");
  retry_pass_a: assert property (o_header_valid |-> o_retry_code == hq[0][9:8])
    else $error("retry code changed");
  prio_pass_a: assert property (o_header_valid |-> o_priority == hq[0][3:0])
    else $error("priority changed");
  sender_pass_a: assert property (
    o_header_valid |-> o_sender_node_address == hq[1][31:16])
    else $error("sender address wrong");
  offset_join_a: assert property (
    o_header_valid |-> o_target_offset == {hq[1][15:0], hq[2]})
    else $error("target offset wrong");
  resp_code_a: assert property (
    o_header_valid |-> o_response_code == (hq[0][7:4] == 4'hB ? hq[1][15:12] : 4'h0))
    else $error("response code wrong");
  transaction_code_pass_a: assert property (o_header_valid |-> o_transaction_code == hq[0][7:4])
    else $error("transaction code changed");
  offset_flag_a: assert property (
    o_header_valid |-> o_offset_misaligned == (hq[2][1:0] != 2'h0))
    else $error("offset alignment flag wrong");
  out_hold_a: assert property (
    o_out_valid && !i_out_ready && i_clock_en |=> o_out_valid && $stable(o_out_data))
    else $error("output quadlet lost while stalled");
endmodule
bind arpf_core arpf_core_checker i_arpf_core_checker (
  .i_clock(i_clock), .i_resetn(i_resetn), .i_clock_en(i_clock_en),
  .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .i_rx_last(i_rx_last),
  .o_rx_ready(o_rx_ready), .o_out_valid(o_out_valid), .o_out_data(o_out_data),
  .i_out_ready(i_out_ready), .o_header_valid(o_header_valid),
  .o_bus_number(o_bus_number), .o_node_number(o_node_number),
  .o_transaction_label(o_transaction_label), .o_retry_code(o_retry_code),
  .o_transaction_code(o_transaction_code),
  .o_priority(o_priority), .o_sender_node_address(o_sender_node_address),
  .o_target_offset(o_target_offset), .o_offset_misaligned(o_offset_misaligned),
  .o_response_code(o_response_code));
`default_nettype wire

// ==== sim/arpf_host_model.sv ====
// Purpose: Host consumer that collects formatted quadlets
// Assumes: Slow service drops ready every other cycle
// Notes:   The bench reads and empties the queues between packets
`default_nettype none
module arpf_host_model (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  input  wire logic        i_clock_en,
  // Service speed
  input  wire logic        i_slow,
  // Formatted stream
  input  wire logic        i_out_valid,
  input  wire logic [31:0] i_out_data,
  input  wire logic        i_out_last,
  output var  logic        o_out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] q[$];
  logic        l[$];
  initial o_out_ready = 1'b1;
  // Moved on the falling edge so the design samples a settled level
  always @(negedge i_clock) begin
    o_out_ready <= i_slow ? ~o_out_ready : 1'b1;
  end
  always @(posedge i_clock) begin
    // A frozen core has not seen the take, so nothing is collected then
    if (i_resetn && i_clock_en && i_out_valid && o_out_ready) begin
      q.push_back(i_out_data);
      l.push_back(i_out_last);
    end
  end
endmodule
`default_nettype wire

// ==== sim/async_receive_packet_formatter_tb_top.sv ====
// Purpose: Self-checking bench for the async receive packet formatter
// Assumes: Clock enable high except in the freeze scenario; consumer stalls on request
// Notes:   Each task sends packets of one kind and judges what leaves
`default_nettype none
`define CHK(nm, ex, sn) begin cmp_count++; if ((sn) !== (ex)) begin n_errors++; \
  $display("BAD %s expected %h seen %h", nm, ex, sn); end end
module async_receive_packet_formatter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] Q1 = 32'h1234_F00D;
  localparam logic [31:0] Q2 = 32'h5678_9ABC; // Offset kept quadlet aligned
  logic        clock;
  logic        resetn = 1'b0;
  logic        dm = 1'b0;
  logic        rx_valid = 1'b0;
  logic [31:0] rx_data = 32'h0;
  logic        rx_last = 1'b0;
  logic [4:0]  ack = 5'h0;
  logic [1:0]  spd = 2'h0;
  logic        slow = 1'b0;
  logic        clock_en = 1'b1;
  wire         rx_ready;
  wire         out_valid;
  wire  [31:0] out_data;
  wire         out_last;
  wire         out_ready;
  wire  [15:0] plen;
  wire  [15:0] pext;
  int          n_errors = 0;
  int          cmp_count = 0;
  logic [31:0] pk[$];
  logic [31:0] ex[$];
  arpf_core i_arpf_core (
    .i_clock(clock), .i_resetn(resetn), .i_clock_en(clock_en), .i_data_mover_port(dm),
    .i_rx_valid(rx_valid), .i_rx_data(rx_data), .i_rx_last(rx_last),
    .i_rx_acknowledge_code(ack), .i_rx_speed(spd), .o_rx_ready(rx_ready),
    .o_out_valid(out_valid), .o_out_data(out_data), .o_out_last(out_last),
    .i_out_ready(out_ready), .o_header_valid(), .o_bus_number(), .o_node_number(),
    .o_transaction_label(), .o_retry_code(), .o_transaction_code(), .o_priority(),
    .o_sender_node_address(), .o_target_offset(), .o_response_code(),
    .o_offset_misaligned(), .o_payload_byte_length(plen),
    .o_extended_transaction_code(pext));
  arpf_host_model i_arpf_host_model (
    .i_clock(clock), .i_resetn(resetn), .i_clock_en(clock_en), .i_slow(slow),
    .i_out_valid(out_valid),
    .i_out_data(out_data), .i_out_last(out_last), .o_out_ready(out_ready));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  function automatic logic [31:0] hdr(input logic [3:0] tc, input logic [1:0] rt);
    return {12'hFFC, tc, 2'h2, tc, rt, tc, 4'h0}; // Zero priority
  endfunction
  function automatic logic [31:0] trl(input int n, input logic [1:0] s);
    return {2'h0, n[13:0], 3'h0, ack, 2'h0, s, 4'h0};
  endfunction
  task automatic run();
    int t;
    logic [31:0] got[$];
    foreach (pk[k]) begin
      @(negedge clock);
      rx_valid = 1'b1;
      rx_data  = pk[k];
      rx_last  = (k == pk.size() - 1);
      // Ready is read at the edge, before that edge's updates land
      @(posedge clock);
      for (t = 0; !(rx_ready && clock_en) && t < 99; t++) @(posedge clock);
      if (t == 99) n_errors++;
    end
    @(negedge clock);
    rx_valid = 1'b0;
    for (t = 0; i_arpf_host_model.q.size() < ex.size() && t < 99; t++) @(negedge clock);
    repeat (3) @(negedge clock);
    got = i_arpf_host_model.q;
    `CHK("quadlet count", ex.size(), got.size())
    foreach (ex[k]) if (k < got.size()) `CHK("quadlet", ex[k], got[k])
    foreach (ex[k]) if (k < got.size()) `CHK("last marker", k == ex.size() - 1, i_arpf_host_model.l[k])
    `CHK("last flag", 1'b1, i_arpf_host_model.l[$])
    i_arpf_host_model.q.delete();
    i_arpf_host_model.l.delete();
  endtask
  task automatic t_quad_data();
    ack = 5'h11;
    spd = 2'h2;
    pk = '{hdr(4'h0, 2'h0), Q1, Q2, 32'hDEAD_BEEF};
    ex = '{trl(4, 2'h2), pk[0], Q1, Q2, 32'hDEAD_BEEF};
    run();
    dm = 1'b1;
    spd = 2'h3;
    pk[0] = hdr(4'h6, 2'h1);
    ex = pk;
    ex.push_back(trl(4, 2'h2));
    run();
  endtask
  task automatic t_quad_bare();
    for (int i = 0; i < 4; i++) begin
      dm = i[0];
      spd = i[1:0];
      ack = 5'(i + 7);
      pk = '{hdr(dm ? 4'h2 : 4'h4, i[1:0]), Q1, Q2, 32'h0BAD_F00D};
      ex = pk[0:2];
      if (dm)
        ex.push_back(trl(3, i == 3 ? 2'h2 : spd));
      else
        ex.push_front(trl(3, i == 3 ? 2'h2 : spd));
      run();
    end
  endtask
  task automatic t_block_write();
    dm = 1'b0;
    slow = 1'b1;
    spd = 2'h1;
    pk = '{hdr(4'h1, 2'h0), Q1, Q2, 32'h0005_0000, 32'h1122_3344, 32'h5566_7788};
    ex = pk[0:4];
    ex.push_back(32'h5500_0000);
    ex.push_back(trl(6, 2'h1));
    run();
    `CHK("length", 16'h0005, plen)
    slow = 1'b0;
  endtask
  task automatic t_block_nodata();
    dm = 1'b1;
    spd = 2'h0;
    ack = 5'h1F;
    pk = '{hdr(4'h5, 2'h3), Q1, Q2, 32'h0008_0000};
    ex = pk;
    ex.push_back(trl(4, 2'h0));
    run();
    `CHK("length", 16'h0008, plen)
    dm = 1'b0;
    pk = '{hdr(4'hB, 2'h2), Q1, Q2, 32'h0004_0002, 32'hCAFE_0001};
    ex = pk;
    ex.push_back(trl(5, 2'h0));
    run();
    `CHK("ext code", 16'h0002, pext)
  endtask
  task automatic t_freeze();
    dm = 1'b0;
    ack = 5'h03;
    spd = 2'h1;
    pk = '{hdr(4'h0, 2'h2), Q1, Q2, 32'h0F0F_A5A5};
    ex = '{trl(4, 2'h1), pk[0], Q1, Q2, 32'h0F0F_A5A5};
    fork
      run();
      repeat (12) begin
        @(negedge clock);
        clock_en = ~clock_en;
      end
    join
  endtask
  task automatic end_sim();
    if (n_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clock);
    @(negedge clock);
    resetn = 1'b1;
    t_quad_data();
    t_quad_bare();
    t_block_write();
    t_block_nodata();
    t_freeze();
    end_sim();
  end
  initial begin
    #20000;
    n_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
